// >>> hdl/tbw_axil_slave.sv
`include "tbw_params.svh"
`default_nettype none
module tbw_axil_slave import tbw_pkg::*; #(
  parameter int AW = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite
  input wire logic [AW-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [AW-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // register side
  output logic wr_req,
  output logic [AW-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic rd_req,
  input wire logic rd_err,
  input wire logic [31:0] rd_data
);
  logic aw_full_q, aw_full_d, w_full_q, w_full_d, bvalid_d, rvalid_d;
  logic awready_d, wready_d, arready_d;
  logic [AW-1:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d, rdata_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic [1:0] bresp_d, rresp_d;

  assign wr_req = aw_full_q & w_full_q & ~s_bvalid;
  assign wr_addr = aw_addr_q;
  assign wr_data = w_data_q;
  assign wr_strb = w_strb_q;
  assign rd_req = s_arvalid & s_arready;

  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    aw_addr_d = aw_addr_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = s_bvalid;
    bresp_d = s_bresp;
    rvalid_d = s_rvalid;
    rresp_d = s_rresp;
    rdata_d = s_rdata;
    if (s_awvalid && s_awready) begin
      aw_full_d = 1'b1;
      aw_addr_d = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      w_full_d = 1'b1;
      w_data_d = s_wdata;
      w_strb_d = s_wstrb;
    end
    if (wr_req) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_err ? `TBW_RESP_SLVERR : `TBW_RESP_OKAY;
    end else if (s_bvalid && s_bready) begin
      bvalid_d = 1'b0;
    end
    if (rd_req) begin
      rvalid_d = 1'b1;
      rdata_d = rd_err ? 32'h0000_0000 : rd_data;
      rresp_d = rd_err ? `TBW_RESP_SLVERR : `TBW_RESP_OKAY;
    end else if (s_rvalid && s_rready) begin
      rvalid_d = 1'b0;
    end
    awready_d = ~aw_full_d & ~bvalid_d;
    wready_d = ~w_full_d & ~bvalid_d;
    arready_d = ~rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= 2'h0;
      s_rvalid <= 1'b0;
      s_rresp <= 2'h0;
      s_rdata <= 32'h0000_0000;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_arready <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      s_bvalid <= bvalid_d;
      s_bresp <= bresp_d;
      s_rvalid <= rvalid_d;
      s_rresp <= rresp_d;
      s_rdata <= rdata_d;
      s_awready <= awready_d;
      s_wready <= wready_d;
      s_arready <= arready_d;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/tbw_params.svh
`ifndef TBW_PARAMS_SVH
`define TBW_PARAMS_SVH
// register byte offsets
`define TBW_OFF_CTRL 8'h00
`define TBW_OFF_STATUS 8'h04
`define TBW_OFF_TRIGCNT 8'h08
`define TBW_OFF_WRPTR 8'h0c
`define TBW_OFF_BASE 8'h10
`define TBW_OFF_LIMIT 8'h14
`define TBW_OFF_ID 8'h18
// control fields
`define TBW_CTRL_EN 0
`define TBW_CTRL_MODE_LO 1
`define TBW_CTRL_MODE_HI 2
`define TBW_CTRL_RST 3'h0
// status fields
`define TBW_ST_BSC_LO 0
`define TBW_ST_BSC_HI 5
`define TBW_ST_HALT 17
`define TBW_ST_ROLL 19
`define TBW_ST_TRG 21
`define TBW_ST_PEND 22
`define TBW_ST_EC_LO 26
`define TBW_ST_EC_HI 31
`define TBW_ST_RST 32'h0000_0000
`define TBW_ST_MASK 32'hfc6a_003f
`define TBW_EC_OTHER 6'h00
`define TBW_BSC_FILLED 6'h01
// id register: log2 of the write unit in the low nibble
`define TBW_ID_ALIGN_LO 0
`define TBW_ID_ALIGN_HI 3
// bus answers
`define TBW_RESP_OKAY 2'h0
`define TBW_RESP_SLVERR 2'h2
`endif

// >>> hdl/tbw_pkg.sv
`default_nettype none
package tbw_pkg;
  typedef enum logic [1:0] {
    TBW_MODE_FILL = 2'b00,
    TBW_MODE_WRAP = 2'b01,
    TBW_MODE_RSVD = 2'b10,
    TBW_MODE_CIRC = 2'b11
  } tbw_mode_t;
endpackage
`default_nettype wire

// >>> hdl/tbw_trig_ctr.sv
`default_nettype none
module tbw_trig_ctr import tbw_pkg::*; #(
  parameter int CW = 32,
  parameter int UNIT = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // software load
  input wire logic load,
  input wire logic [CW-1:0] load_val,
  // trigger and write activity
  input wire logic enable,
  input wire logic det_trig,
  input wire logic seen,
  input wire logic unit_wr,
  output logic [CW-1:0] cnt_q,
  output logic fire
);
  localparam logic [CW-1:0] UNIT_C = CW'(UNIT);
  logic [CW-1:0] cnt_d;
  logic counting;

  assign counting = unit_wr & seen & (cnt_q != '0);

  always_comb begin
    cnt_d = cnt_q;
    fire = 1'b0;
    // whole unit per memory write; a short tail saturates at zero
    if (counting) begin
      cnt_d = (cnt_q <= UNIT_C) ? '0 : cnt_q - UNIT_C;
    end
    // no early over-decrement on a trigger with an unseen flag
    if (enable) begin
      fire = (det_trig & (cnt_q == '0) & ~seen)
        | (counting & (cnt_q <= UNIT_C));
    end
    if (load) begin
      cnt_d = load_val;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/tbw_wrap_trigger.sv
`include "tbw_params.svh"
`default_nettype none
module tbw_wrap_trigger import tbw_pkg::*; #(
  parameter int PW = 32,
  parameter int UNIT_LOG2 = 3,
  parameter int CW = 32
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite register port
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // trace unit side
  input wire logic trace_wr_valid,
  input wire logic [(8<<UNIT_LOG2)-1:0] trace_wr_data,
  input wire logic trace_wr_fault,
  output logic trace_wr_ready,
  input wire logic detected_trigger,
  // memory write side
  output logic mem_wr_valid,
  output logic [PW-1:0] mem_wr_addr,
  output logic [(8<<UNIT_LOG2)-1:0] mem_wr_data,
  // events
  output logic pointer_rollover_pmu_event,
  output logic trigger_event,
  output logic buffer_mgmt_interrupt_line
);
  localparam int UNIT = 1 << UNIT_LOG2;
  localparam int DW = 8 * UNIT;
  localparam logic [PW-1:0] UNIT_P = PW'(UNIT);

  logic wr_req, wr_err, rd_req, rd_err;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data, bmask;
  logic [3:0] wr_strb;

  logic [2:0] ctrl_q, ctrl_d;
  logic [31:0] buffer_status_register, status_d;
  logic [PW-1:0] ptr_q, ptr_d, base_q, base_d, limit_q, limit_d, ptr_sum;
  logic [CW-1:0] cnt_q;
  logic [31:0] buffer_id_register;
  logic enable;
  tbw_mode_t mode;
  logic halted, seen, accept, unit_wr, wrap, fire;
  logic st_wr, ptr_wr, cnt_ld, ctrl_wr, base_wr, limit_wr;
  logic ready_d, mwv_d, pmu_d, trig_d;
  logic [PW-1:0] mwa_d;
  logic [DW-1:0] mwd_d;

  assign rd_addr = s_araddr;

  tbw_axil_slave #(
    .AW(8)
  ) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_req(wr_req),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_req(rd_req),
    .rd_err(rd_err),
    .rd_data(rd_data)
  );

  // byte-lane mask from write strobes
  assign bmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  // write decode
  always_comb begin
    ctrl_wr = 1'b0;
    st_wr = 1'b0;
    cnt_ld = 1'b0;
    ptr_wr = 1'b0;
    base_wr = 1'b0;
    limit_wr = 1'b0;
    wr_err = 1'b0;
    if (wr_req) begin
      unique case (wr_addr)
        `TBW_OFF_CTRL: ctrl_wr = 1'b1;
        `TBW_OFF_STATUS: st_wr = 1'b1;
        `TBW_OFF_TRIGCNT: cnt_ld = 1'b1;
        `TBW_OFF_WRPTR: ptr_wr = 1'b1;
        `TBW_OFF_BASE: base_wr = 1'b1;
        `TBW_OFF_LIMIT: limit_wr = 1'b1;
        `TBW_OFF_ID: wr_err = 1'b0;
        default: wr_err = 1'b1;
      endcase
    end
  end

  // read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (rd_addr)
      `TBW_OFF_CTRL: rd_data = {29'h0, ctrl_q};
      `TBW_OFF_STATUS: rd_data = buffer_status_register;
      `TBW_OFF_TRIGCNT: rd_data = 32'(cnt_q);
      `TBW_OFF_WRPTR: rd_data = 32'(ptr_q);
      `TBW_OFF_BASE: rd_data = 32'(base_q);
      `TBW_OFF_LIMIT: rd_data = 32'(limit_q);
      `TBW_OFF_ID: rd_data = buffer_id_register;
      default: rd_err = 1'b1;
    endcase
  end

  always_comb begin
    buffer_id_register = 32'h0000_0000;
    buffer_id_register[`TBW_ID_ALIGN_HI:`TBW_ID_ALIGN_LO] = 4'(UNIT_LOG2);
  end

  assign enable = ctrl_q[`TBW_CTRL_EN];
  assign mode = tbw_mode_t'(ctrl_q[`TBW_CTRL_MODE_HI:`TBW_CTRL_MODE_LO]);
  assign halted = buffer_status_register[`TBW_ST_HALT];
  assign seen = buffer_status_register[`TBW_ST_TRG];

  // pointer advance and wrap detection
  assign accept = trace_wr_valid & trace_wr_ready & ~halted;
  assign unit_wr = accept & ~trace_wr_fault;
  assign ptr_sum = ptr_q + UNIT_P;
  assign wrap = unit_wr & (ptr_sum >= limit_q);

  tbw_trig_ctr #(
    .CW(CW),
    .UNIT(UNIT)
  ) u_trig (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(cnt_ld),
    .load_val(CW'(wr_data)),
    .enable(enable),
    .det_trig(detected_trigger),
    .seen(seen),
    .unit_wr(unit_wr),
    .cnt_q(cnt_q),
    .fire(fire)
  );

  // configuration registers
  always_comb begin
    ctrl_d = ctrl_q;
    base_d = base_q;
    limit_d = limit_q;
    ptr_d = ptr_q;
    if (ctrl_wr && wr_strb[0]) begin
      ctrl_d = wr_data[2:0];
    end
    if (base_wr) begin
      base_d = PW'((32'(base_q) & ~bmask) | (wr_data & bmask));
    end
    if (limit_wr) begin
      limit_d = PW'((32'(limit_q) & ~bmask) | (wr_data & bmask));
    end
    if (ptr_wr) begin
      ptr_d = PW'((32'(ptr_q) & ~bmask) | (wr_data & bmask));
    end
    // hardware advance takes priority over a software pointer write
    if (unit_wr) begin
      ptr_d = wrap ? base_q : ptr_sum;
    end
  end

  // status register: hardware sets win over a same-cycle software write
  always_comb begin
    status_d = buffer_status_register;
    if (st_wr) begin
      status_d = ((buffer_status_register & ~bmask) | (wr_data & bmask)) & `TBW_ST_MASK;
    end
    if (wrap) begin
      status_d[`TBW_ST_ROLL] = 1'b1;
      unique case (mode)
        TBW_MODE_WRAP: begin
          status_d[`TBW_ST_PEND] = 1'b1;
        end
        TBW_MODE_CIRC: begin
          status_d[`TBW_ST_PEND] = status_d[`TBW_ST_PEND];
        end
        default: begin
          status_d[`TBW_ST_PEND] = 1'b1;
          if (!halted) begin
            status_d[`TBW_ST_HALT] = 1'b1;
            status_d[`TBW_ST_EC_HI:`TBW_ST_EC_LO] = `TBW_EC_OTHER;
            status_d[`TBW_ST_BSC_HI:`TBW_ST_BSC_LO] = `TBW_BSC_FILLED;
          end
        end
      endcase
    end
    if (detected_trigger && enable) begin
      status_d[`TBW_ST_TRG] = 1'b1;
    end
  end

  // output flops
  always_comb begin
    ready_d = ctrl_d[`TBW_CTRL_EN] & ~status_d[`TBW_ST_HALT];
    mwv_d = unit_wr;
    mwa_d = unit_wr ? ptr_q : mem_wr_addr;
    mwd_d = unit_wr ? trace_wr_data : mem_wr_data;
    pmu_d = wrap;
    trig_d = fire;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `TBW_CTRL_RST;
      buffer_status_register <= `TBW_ST_RST;
      ptr_q <= '0;
      base_q <= '0;
      limit_q <= '0;
      trace_wr_ready <= 1'b0;
      mem_wr_valid <= 1'b0;
      mem_wr_addr <= '0;
      mem_wr_data <= '0;
      pointer_rollover_pmu_event <= 1'b0;
      trigger_event <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      buffer_status_register <= status_d;
      ptr_q <= ptr_d;
      base_q <= base_d;
      limit_q <= limit_d;
      trace_wr_ready <= ready_d;
      mem_wr_valid <= mwv_d;
      mem_wr_addr <= mwa_d;
      mem_wr_data <= mwd_d;
      pointer_rollover_pmu_event <= pmu_d;
      trigger_event <= trig_d;
    end
  end

  // level interrupt straight from the pending flop
  assign buffer_mgmt_interrupt_line = buffer_status_register[`TBW_ST_PEND];

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_fill_wrap;
    wrap && mode == TBW_MODE_FILL |=> buffer_mgmt_interrupt_line
      && buffer_status_register[`TBW_ST_ROLL] && pointer_rollover_pmu_event;
  endproperty
  a_fill_wrap: assert property (p_fill_wrap)
    else $error("fill wrap did not raise pending, rollover and event");

  property p_fill_halt;
    wrap && mode == TBW_MODE_FILL && !halted |=> halted && !trace_wr_ready
      && buffer_status_register[`TBW_ST_EC_HI:`TBW_ST_EC_LO] == `TBW_EC_OTHER
      && buffer_status_register[`TBW_ST_BSC_HI:`TBW_ST_BSC_LO] == `TBW_BSC_FILLED;
  endproperty
  a_fill_halt: assert property (p_fill_halt)
    else $error("fill wrap did not stop collection with filled code");

  property p_fill_ptr;
    wrap && mode == TBW_MODE_FILL && !st_wr |=> ptr_q == $past(base_q)
      && (seen == $past(seen) || $past(detected_trigger));
  endproperty
  a_fill_ptr: assert property (p_fill_ptr)
    else $error("fill wrap left pointer off base");

  property p_wrap_mode;
    wrap && mode == TBW_MODE_WRAP && !st_wr |=> buffer_mgmt_interrupt_line
      && pointer_rollover_pmu_event
      && buffer_status_register[`TBW_ST_BSC_HI:`TBW_ST_BSC_LO]
        == $past(buffer_status_register[`TBW_ST_BSC_HI:`TBW_ST_BSC_LO]);
  endproperty
  a_wrap_mode: assert property (p_wrap_mode)
    else $error("wrap-mode wrap handled wrongly");

  property p_wrap_runs;
    wrap && mode == TBW_MODE_WRAP && !halted && !st_wr && ctrl_d[`TBW_CTRL_EN]
      |=> !halted && trace_wr_ready;
  endproperty
  a_wrap_runs: assert property (p_wrap_runs)
    else $error("wrap mode stopped collection");

  property p_circ;
    wrap && mode == TBW_MODE_CIRC && !st_wr |=> pointer_rollover_pmu_event
      && buffer_status_register[`TBW_ST_ROLL]
      && buffer_mgmt_interrupt_line == $past(buffer_mgmt_interrupt_line);
  endproperty
  a_circ: assert property (p_circ)
    else $error("circular wrap raised a request or missed rollover");

  property p_halt_freeze;
    halted && !ptr_wr |=> ptr_q == $past(ptr_q) && !pointer_rollover_pmu_event;
  endproperty
  a_halt_freeze: assert property (p_halt_freeze)
    else $error("pointer moved while halted");

  property p_trig_seen;
    detected_trigger && enable |=> seen;
  endproperty
  a_trig_seen: assert property (p_trig_seen)
    else $error("trigger-seen flag not set");

  property p_cnt_dec;
    unit_wr && seen && cnt_q > CW'(UNIT) && !cnt_ld
      |=> cnt_q == $past(cnt_q) - CW'(UNIT);
  endproperty
  a_cnt_dec: assert property (p_cnt_dec)
    else $error("trigger counter not decremented by the unit");

  property p_trig_direct;
    detected_trigger && enable && cnt_q == '0 && !seen |=> trigger_event;
  endproperty
  a_trig_direct: assert property (p_trig_direct)
    else $error("zero counter trigger gave no event");

  property p_trig_once;
    detected_trigger && seen && cnt_q == '0 |=> !trigger_event;
  endproperty
  a_trig_once: assert property (p_trig_once)
    else $error("event raised for repeated trigger");

  property p_trig_en;
    !enable |=> !trigger_event;
  endproperty
  a_trig_en: assert property (p_trig_en)
    else $error("trigger event while disabled");

  property p_irq_hold;
    buffer_mgmt_interrupt_line && !st_wr |=> buffer_mgmt_interrupt_line;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped without software clear");
endmodule
`default_nettype wire

// >>> verification/tbw_trace_model.sv
`default_nettype none
module tbw_trace_model #(
  parameter int DW = 64
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bench control
  input wire logic start,
  input wire logic [7:0] n_units,
  input wire logic fault_mode,
  input wire logic trig_req,
  output logic busy,
  // trace port
  output logic trace_wr_valid,
  output logic [DW-1:0] trace_wr_data,
  output logic trace_wr_fault,
  input wire logic trace_wr_ready,
  output logic detected_trigger
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] todo_q;
  assign busy = (todo_q != 8'h00);
  assign trace_wr_fault = fault_mode;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      todo_q <= 8'h00;
      trace_wr_valid <= 1'b0;
      trace_wr_data <= '0;
      detected_trigger <= 1'b0;
    end else begin
      detected_trigger <= trig_req;
      // start with zero units also abandons a unit that is never taken
      if (start) begin
        todo_q <= n_units;
        trace_wr_valid <= 1'b0;
        trace_wr_data <= ~trace_wr_data;
      end else if (trace_wr_valid && trace_wr_ready) begin
        todo_q <= todo_q - 8'h01;
        trace_wr_valid <= 1'b0;
        trace_wr_data <= ~trace_wr_data;
      end else if (!trace_wr_valid && busy && ($urandom_range(0, 1) == 0)) begin
        trace_wr_valid <= 1'b1;
        trace_wr_data <= {$urandom, $urandom};
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/tbw_wrap_trigger_tb_top.sv
`include "tbw_params.svh"
`default_nettype none
module tbw_wrap_trigger_tb_top import tbw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00, n_units = 8'h00;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_arvalid = 1'b0;
  logic s_bready = 1'b1, s_rready = 1'b1, start = 1'b0, fault_mode = 1'b0, trig_req = 1'b0;
  logic [31:0] s_wdata = 32'h0, s_rdata, rd, cnt, last_addr, mem_wr_addr;
  logic [3:0] s_wstrb = 4'hf;
  logic [1:0] s_bresp, s_rresp, rr, br;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, busy;
  logic trace_wr_valid, trace_wr_fault, trace_wr_ready, detected_trigger;
  logic [63:0] trace_wr_data, mem_wr_data, exp_data;
  logic mem_wr_valid, pointer_rollover_pmu_event, trigger_event, buffer_mgmt_interrupt_line;
  int n_fail = 0, n_compared = 0, n_roll = 0, n_trig = 0, n_mem = 0, n, t;
  always #25 aclk = ~aclk;
  tbw_wrap_trigger dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .trace_wr_valid(trace_wr_valid), .trace_wr_data(trace_wr_data),
    .trace_wr_fault(trace_wr_fault), .trace_wr_ready(trace_wr_ready),
    .detected_trigger(detected_trigger), .mem_wr_valid(mem_wr_valid),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .pointer_rollover_pmu_event(pointer_rollover_pmu_event),
    .trigger_event(trigger_event), .buffer_mgmt_interrupt_line(buffer_mgmt_interrupt_line));
  tbw_trace_model model (.aclk(aclk), .aresetn(aresetn), .start(start), .n_units(n_units),
    .fault_mode(fault_mode), .trig_req(trig_req), .busy(busy),
    .trace_wr_valid(trace_wr_valid), .trace_wr_data(trace_wr_data),
    .trace_wr_fault(trace_wr_fault), .trace_wr_ready(trace_wr_ready),
    .detected_trigger(detected_trigger));
  always @(posedge aclk) begin
    if (pointer_rollover_pmu_event === 1'b1) n_roll++;
    if (trigger_event === 1'b1) n_trig++;
    if (trace_wr_valid && trace_wr_ready) exp_data <= trace_wr_data;
    if (mem_wr_valid === 1'b1) begin
      n_mem++;
      last_addr <= mem_wr_addr;
      chk(mem_wr_data[63:32], exp_data[63:32]);
      chk(mem_wr_data[31:0], exp_data[31:0]);
    end
  end
  function automatic logic [31:0] st_word(input logic h, r, g, p, input logic [5:0] buffer_status_code);
    st_word = 32'h0;
    st_word[`TBW_ST_BSC_HI:`TBW_ST_BSC_LO] = buffer_status_code;
    st_word[`TBW_ST_HALT] = h;
    st_word[`TBW_ST_ROLL] = r;
    st_word[`TBW_ST_TRG] = g;
    st_word[`TBW_ST_PEND] = p;
    st_word[`TBW_ST_EC_HI:`TBW_ST_EC_LO] = `TBW_EC_OTHER;
  endfunction
  function automatic logic [31:0] ctrl_word(input tbw_mode_t m, input logic en);
    ctrl_word = {29'h0, m, en};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_awready) begin aw_done = 1'b1; s_awvalid <= 1'b0; end
      if (!w_done && s_wready) begin w_done = 1'b1; s_wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (s_bvalid !== 1'b1);
    br = s_bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(posedge aclk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    do @(posedge aclk); while (s_rvalid !== 1'b1);
    d = s_rdata;
    r = s_rresp;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, rd, rr);
    chk(rd, exp);
  endtask
  task automatic send(input int k);
    int i;
    start <= 1'b1;
    n_units <= 8'(k);
    @(posedge aclk);
    start <= 1'b0;
    @(posedge aclk);
    for (i = 0; i < 40 && busy; i++) @(posedge aclk);
    start <= 1'b1;
    n_units <= 8'h00;
    @(posedge aclk);
    start <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic trig();
    trig_req <= 1'b1;
    @(posedge aclk);
    trig_req <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic final_report();
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    void'($urandom(13));
    rd_chk(`TBW_OFF_STATUS, `TBW_ST_RST);
    axi_rd(`TBW_OFF_ID, rd, rr);
    chk({28'h0, rd[3:0]}, 32'h3);
    axi_rd(8'h40, rd, rr);
    chk({30'h0, rr}, {30'h0, `TBW_RESP_SLVERR});
    chk(rd, 32'h0);
    axi_wr(8'h40, 32'h0);
    chk({30'h0, br}, {30'h0, `TBW_RESP_SLVERR});
    // fill: four units reach the limit, then collection stops
    axi_wr(`TBW_OFF_BASE, 32'h100);
    chk({30'h0, br}, {30'h0, `TBW_RESP_OKAY});
    axi_wr(`TBW_OFF_LIMIT, 32'h120);
    axi_wr(`TBW_OFF_WRPTR, 32'h100);
    axi_wr(`TBW_OFF_CTRL, ctrl_word(TBW_MODE_FILL, 1'b1));
    send(3);
    chk(n_roll, 0);
    send(1);
    chk(n_roll, 1);
    chk(last_addr, 32'h118);
    rd_chk(`TBW_OFF_STATUS, st_word(1, 1, 0, 1, `TBW_BSC_FILLED));
    rd_chk(`TBW_OFF_WRPTR, 32'h100);
    chk({31'h0, buffer_mgmt_interrupt_line}, 32'h1);
    send(2);
    chk(n_mem, 32'd4);
    chk({31'h0, trace_wr_ready}, 32'h0);
    rd_chk(`TBW_OFF_WRPTR, 32'h100);
    axi_wr(`TBW_OFF_STATUS, 32'h0);
    @(posedge aclk);
    chk({31'h0, buffer_mgmt_interrupt_line}, 32'h0);
    // wrap: interrupt request but collection continues
    axi_wr(`TBW_OFF_WRPTR, 32'h118);
    axi_wr(`TBW_OFF_CTRL, ctrl_word(TBW_MODE_WRAP, 1'b1));
    send(2);
    chk(n_roll, 2);
    chk(last_addr, 32'h100);
    rd_chk(`TBW_OFF_STATUS, st_word(0, 1, 0, 1, 6'h00));
    chk(n_mem, 32'd6);
    chk({31'h0, trace_wr_ready}, 32'h1);
    rd_chk(`TBW_OFF_WRPTR, 32'h108);
    // circular: rollover only
    axi_wr(`TBW_OFF_STATUS, 32'h0);
    axi_wr(`TBW_OFF_WRPTR, 32'h118);
    axi_wr(`TBW_OFF_CTRL, ctrl_word(TBW_MODE_CIRC, 1'b1));
    send(1);
    chk(n_roll, 3);
    rd_chk(`TBW_OFF_STATUS, st_word(0, 1, 0, 0, 6'h00));
    chk({31'h0, buffer_mgmt_interrupt_line}, 32'h0);
    // zero counter: event follows the trigger, a repeat trigger is ignored
    axi_wr(`TBW_OFF_STATUS, 32'h0);
    axi_wr(`TBW_OFF_TRIGCNT, 32'h0);
    trig();
    chk(n_trig, 1);
    rd_chk(`TBW_OFF_STATUS, st_word(0, 0, 1, 0, 6'h00));
    trig();
    chk(n_trig, 1);
    // random nonzero count, faulted unit first
    axi_wr(`TBW_OFF_STATUS, 32'h0);
    n = $urandom_range(2, 4);
    cnt = 32'(n * 8) - 32'($urandom_range(0, 7));
    axi_wr(`TBW_OFF_TRIGCNT, cnt);
    trig();
    chk(n_trig, 1);
    rd_chk(`TBW_OFF_TRIGCNT, cnt);
    fault_mode <= 1'b1;
    t = n_mem;
    send(1);
    fault_mode <= 1'b0;
    chk(n_mem, t);
    rd_chk(`TBW_OFF_TRIGCNT, cnt);
    send(n - 1);
    chk(n_trig, 1);
    rd_chk(`TBW_OFF_TRIGCNT, cnt - 32'((n - 1) * 8));
    send(1);
    chk(n_trig, 2);
    rd_chk(`TBW_OFF_TRIGCNT, 32'h0);
    // disabled unit raises no trigger event
    axi_wr(`TBW_OFF_CTRL, ctrl_word(TBW_MODE_FILL, 1'b0));
    axi_wr(`TBW_OFF_STATUS, 32'h0);
    trig();
    chk(n_trig, 2);
    final_report();
  end
endmodule
`default_nettype wire
